// file: verilog/azd_pkg.sv
// constants, types and helper functions of the ambient zone decision block
package azd_pkg;
  // ****************
  // timing
  // ****************
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned SAMPLE_PERIOD_NS = 140_000;
  localparam int unsigned FAST_PERIOD_NS = 1_100_000;
  localparam int unsigned BASE_PERIOD_NS = 8_000_000;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_NS * CLK_MHZ / 1000;
  localparam int unsigned FAST_CYCLES = FAST_PERIOD_NS * CLK_MHZ / 1000;
  localparam int unsigned BASE_CYCLES = BASE_PERIOD_NS * CLK_MHZ / 1000;
  localparam logic [1:0] FAST_PERIODS = 2'h3;
  localparam logic [5:0] UP_PERIODS = 6'h03;
  localparam logic [5:0] DOWN_BASE_PERIODS = 6'h03;
  localparam logic [5:0] DOWN_EXTRA_MIN = 6'h03;
  // ****************
  // register map
  // ****************
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_DOWN_DELAY = 8'h04;
  localparam logic [7:0] REG_AVG_RESULT = 8'h08;
  localparam logic [7:0] REG_ZONE_INFO = 8'h0c;
  localparam logic [7:0] REG_BOUND_HIGH = 8'h10;
  localparam logic [7:0] REG_BOUND_LOW = 8'h14;
  localparam logic [7:0] REG_TARGET_LOW = 8'h18;
  localparam logic [7:0] REG_TARGET_FOUR = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam int CFG_ALGO_BIT = 0;
  localparam int CFG_EN_BIT = 3;
  localparam int CFG_SEL_LSB = 4;
  localparam int INFO_FLAG_BIT = 3;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [4:0] DOWN_DELAY_RESET = 5'h00;
  localparam logic [31:0] BOUND_HIGH_RESET = 32'hc8_98_68_38;
  localparam logic [31:0] BOUND_LOW_RESET = 32'hc0_90_60_30;
  localparam logic [31:0] TARGET_LOW_RESET = 32'hc0_80_40_10;
  localparam logic [7:0] TARGET_FOUR_RESET = 8'hff;
  // ****************
  // types
  // ****************
  typedef enum logic [1:0] {AZD_BUS_IDLE = 2'b00, AZD_BUS_WAIT = 2'b01, AZD_BUS_DONE = 2'b11} azd_bus_e;
  typedef enum logic [1:0] {AZD_RUN_NONE = 2'b00, AZD_RUN_UP = 2'b01, AZD_RUN_DOWN = 2'b11} azd_run_e;
  // ****************
  // functions
  // ****************
  function automatic logic [5:0] azd_need(input logic down, input logic algo, input logic [4:0] code);
    if (down && algo) begin
      return DOWN_BASE_PERIODS + DOWN_EXTRA_MIN + {1'b0, code};
    end
    return down ? DOWN_BASE_PERIODS : UP_PERIODS;
  endfunction
  function automatic logic [31:0] azd_period_len(input logic fast, input logic [2:0] sel,
                                                 input logic [31:0] fast_cyc, input logic [31:0] base_cyc);
    return fast ? fast_cyc : (base_cyc << sel);
  endfunction
  function automatic logic [2:0] azd_classify(input logic [2:0] cur, input logic [7:0] lvl,
                                              input logic [3:0][7:0] hi, input logic [3:0][7:0] lo);
    logic [2:0] z;
    z = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (cur > 3'(i)) begin
        if (lvl >= lo[i]) begin
          z = 3'(i + 1);
        end
      end else if (lvl > hi[i]) begin
        z = 3'(i + 1);
      end
    end
    return z;
  endfunction
endpackage

// file: verilog/azd_link_if.sv
// carrier between the decision top, the averager and the zone map
`timescale 1ns/10ps
`default_nettype none
interface azd_link_if;
  logic clear;
  logic sample_tick;
  logic [7:0] sample_data;
  logic period_end;
  logic [7:0] avg_result;
  logic avg_valid;
  logic [3:0][7:0] bnd_hi;
  logic [3:0][7:0] bnd_lo;
  logic [2:0] zone;
  logic zone_valid;
  modport avg (input clear, sample_tick, sample_data, period_end, output avg_result, avg_valid);
  modport zmap (input clear, avg_result, avg_valid, bnd_hi, bnd_lo, output zone, zone_valid);
endinterface
`default_nettype wire

// file: verilog/azd_averager.sv
// sample averager over one averaging period
`timescale 1ns/10ps
`default_nettype none
module azd_averager import azd_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  azd_link_if.avg lk
);
  typedef struct packed {
    logic [23:0] sum;
    logic [15:0] cnt;
    logic [7:0] result;
    logic valid;
  } azd_avg_s;
  azd_avg_s s, next_s;
  // ****************
  // accumulate and divide
  // ****************
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    if (lk.clear) begin
      next_s = '0;
    end else begin
      if (lk.period_end) begin
        // [RULE20] whole period mean
        if (s.cnt != 16'h0000) begin
          next_s.result = 8'(s.sum / 24'(s.cnt));
        end
        next_s.valid = 1'b1;
        next_s.sum = '0;
        next_s.cnt = '0;
      end
      if (lk.sample_tick) begin
        next_s.sum = next_s.sum + 24'(lk.sample_data);
        next_s.cnt = next_s.cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign lk.avg_result = s.result;
  assign lk.avg_valid = s.valid;
  property p_avg_value;
    @(posedge sys_clk) disable iff (rst)
    (lk.period_end && !lk.clear && s.cnt != 16'h0000) |=> (s.result == 8'($past(s.sum) / 24'($past(s.cnt))));
  endproperty
  a_avg_value: assert property (p_avg_value) else $error("average result wrong"); // [RULE1]
endmodule
`default_nettype wire

// file: verilog/azd_zone_map.sv
// hysteresis zone classifier holding the averager output zone
`timescale 1ns/10ps
`default_nettype none
module azd_zone_map import azd_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  azd_link_if.zmap lk
);
  typedef struct packed {
    logic [2:0] zone;
    logic valid;
  } azd_zone_s;
  azd_zone_s s, next_s;
  // ****************
  // classify
  // ****************
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    if (lk.clear) begin
      next_s.zone = 3'h0;
    end else if (lk.avg_valid) begin
      // [RULE19] five zones hysteresis
      next_s.zone = azd_classify(s.zone, lk.avg_result, lk.bnd_hi, lk.bnd_lo);
      next_s.valid = 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // [RULE8] zone held between results
  assign lk.zone = s.zone;
  assign lk.zone_valid = s.valid;
  property p_zone_range;
    @(posedge sys_clk) disable iff (rst)
    s.valid |-> (s.zone <= 3'h4);
  endproperty
  a_zone_range: assert property (p_zone_range) else $error("zone out of range"); // [RULE19]
  property p_zone_hold;
    @(posedge sys_clk) disable iff (rst)
    (!lk.avg_valid && !lk.clear) |=> $stable(s.zone);
  endproperty
  a_zone_hold: assert property (p_zone_hold) else $error("zone moved mid period"); // [RULE8]
endmodule
`default_nettype wire

// file: verilog/azd_top.sv
// ambient zone decision block with its AHB-Lite register slave
//
// Behaviour
// [RULE1] average result register readable by software
// [RULE2] sensing start sets zone zero
// [RULE3] three fast 1.1 ms periods at start
// [RULE4] raise target after three upward periods
// [RULE5] lower target after three downward periods
// [RULE6] further same-direction change moves target at once
// [RULE7] no change or reversal rearms criterion
// [RULE8] output zone from last complete period
// [RULE9] target changes only at period start
// [RULE10] brightness is target of held zone
// [RULE11] direct mode uses common rules only
// [RULE12] down-delay mode adds waits for decreases
// [RULE13] delay code adds three to thirty-four
// [RULE14] interrupt pulls low on zone change
// [RULE15] zone and flag bit 3 loaded together
// [RULE16] zone info read clears flag, releases
// [RULE17] upward change abandons pending delayed decrease
// [RULE18] sensing runs only with enable bit 3
// [RULE19] five zones, four hysteresis boundaries
// [RULE20] sampling at 7.143 ksps each period
`timescale 1ns/10ps
`default_nettype none
module azd_top import azd_pkg::*; #(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES,
  parameter int unsigned FAST_CYC = FAST_CYCLES,
  parameter int unsigned BASE_CYC = BASE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] sample_data,
  output logic sample_strobe,
  output logic conv_enable,
  output logic [7:0] brightness,
  output logic [2:0] target_zone,
  output logic irq_out,
  output logic irq_oe_n
);
  typedef struct packed {
    azd_bus_e bus;
    logic [7:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic [7:0] cfg;
    logic [4:0] ddelay;
    logic [31:0] bnd_hi;
    logic [31:0] bnd_lo;
    logic [31:0] tgt_lo;
    logic [7:0] tgt4;
    logic en_d;
    logic [31:0] smp_cnt;
    logic tick;
    logic [31:0] per_cnt;
    logic per_end;
    logic [1:0] fast_left;
    logic [1:0] fast_zv;
    logic [2:0] prev_zone;
    logic [2:0] target;
    logic armed;
    logic armed_up;
    azd_run_e run;
    logic [5:0] run_cnt;
    logic flag;
    logic [2:0] info_zone;
    logic [7:0] bright;
  } azd_top_s;
  azd_top_s s, next_s;
  azd_link_if link();
  logic en;
  logic start;
  logic take;
  logic up;
  logic dn;
  logic zone_new;
  logic [31:0] len;
  azd_run_e dir;
  logic [5:0] cnt;
  logic [39:0] tgt_all;
  assign en = s.cfg[CFG_EN_BIT];
  assign start = en && !s.en_d;
  assign take = hsel && hready && htrans[1] && (s.bus != AZD_BUS_WAIT);
  assign up = link.zone > s.prev_zone;
  assign dn = link.zone < s.prev_zone;
  assign zone_new = link.zone_valid && en && (link.zone != s.prev_zone);
  assign len = azd_period_len(s.fast_left != 2'h0, s.cfg[CFG_SEL_LSB +: 3], FAST_CYC, BASE_CYC);
  assign tgt_all = {s.tgt4, s.tgt_lo};
  // ****************
  // next state
  // ****************
  always_comb begin
    next_s = s;
    dir = AZD_RUN_NONE;
    cnt = 6'h00;
    next_s.tick = 1'b0;
    next_s.per_end = 1'b0;
    next_s.en_d = en;
    // bus slave: one wait state, then OKAY
    case (s.bus)
      AZD_BUS_IDLE, AZD_BUS_DONE: begin
        next_s.bus = take ? AZD_BUS_WAIT : AZD_BUS_IDLE;
        if (take) begin
          next_s.addr = {haddr[7:2], 2'b00};
          next_s.wr = hwrite;
        end
      end
      AZD_BUS_WAIT: begin
        next_s.bus = AZD_BUS_DONE;
        next_s.rdata = 32'h0000_0000;
        if (s.wr) begin
          case (s.addr)
            REG_CONFIG: next_s.cfg = hwdata[7:0];
            REG_DOWN_DELAY: next_s.ddelay = hwdata[4:0];
            REG_BOUND_HIGH: next_s.bnd_hi = hwdata;
            REG_BOUND_LOW: next_s.bnd_lo = hwdata;
            REG_TARGET_LOW: next_s.tgt_lo = hwdata;
            REG_TARGET_FOUR: next_s.tgt4 = hwdata[7:0];
            default: next_s.cfg = s.cfg;
          endcase
        end else begin
          case (s.addr)
            REG_CONFIG: next_s.rdata = {24'h00_0000, s.cfg};
            REG_DOWN_DELAY: next_s.rdata = {27'h000_0000, s.ddelay};
            // [RULE1] average readback
            REG_AVG_RESULT: next_s.rdata = {24'h00_0000, link.avg_result};
            REG_ZONE_INFO: begin
              next_s.rdata = {28'h000_0000, s.flag, s.info_zone};
              // [RULE16] read clears flag
              next_s.flag = 1'b0;
            end
            REG_BOUND_HIGH: next_s.rdata = s.bnd_hi;
            REG_BOUND_LOW: next_s.rdata = s.bnd_lo;
            REG_TARGET_LOW: next_s.rdata = s.tgt_lo;
            REG_TARGET_FOUR: next_s.rdata = {24'h00_0000, s.tgt4};
            REG_STATUS: next_s.rdata = {16'h0000, s.bright, s.armed, link.zone, 1'b0, s.target};
            default: next_s.rdata = 32'h0000_0000;
          endcase
        end
      end
      default: next_s.bus = AZD_BUS_IDLE;
    endcase
    // [RULE18] sensing only while enabled
    if (!en) begin
      next_s.smp_cnt = '0;
      next_s.per_cnt = '0;
    end else if (start) begin
      // [RULE2] known zone at start
      next_s.smp_cnt = '0;
      next_s.per_cnt = '0;
      next_s.fast_left = FAST_PERIODS;
      next_s.fast_zv = FAST_PERIODS;
      next_s.prev_zone = 3'h0;
      next_s.target = 3'h0;
      next_s.armed = 1'b0;
      next_s.run = AZD_RUN_NONE;
      next_s.run_cnt = 6'h00;
    end else begin
      // [RULE20] fixed rate sample strobe
      if (s.smp_cnt >= SAMPLE_CYC - 1) begin
        next_s.smp_cnt = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.smp_cnt = s.smp_cnt + 32'h0000_0001;
      end
      // [RULE3] fast periods at start
      if (s.per_cnt >= len - 32'h0000_0001) begin
        next_s.per_cnt = '0;
        next_s.per_end = 1'b1;
        if (s.fast_left != 2'h0) begin
          next_s.fast_left = s.fast_left - 2'h1;
        end
      end else begin
        next_s.per_cnt = s.per_cnt + 32'h0000_0001;
      end
    end
    // [RULE9] decisions at period start
    if (link.zone_valid && !start) begin
      next_s.prev_zone = link.zone;
      // [RULE15] zone and flag together
      if (zone_new) begin
        next_s.flag = 1'b1;
        next_s.info_zone = link.zone;
      end
      if (s.fast_zv != 2'h0) begin
        next_s.fast_zv = s.fast_zv - 2'h1;
        next_s.target = link.zone;
      end else if (s.armed && ((s.armed_up && up) || (!s.armed_up && dn))) begin
        // [RULE6] same direction at once
        next_s.target = link.zone;
      end else begin
        // [RULE7] criterion must rebuild
        next_s.armed = 1'b0;
        if (up || dn) begin
          dir = up ? AZD_RUN_UP : AZD_RUN_DOWN;
          // [RULE17] reversal restarts count
          cnt = (!s.armed && s.run == dir) ? s.run_cnt + 6'h01 : 6'h01;
        end else if (!s.armed && s.run != AZD_RUN_NONE) begin
          dir = s.run;
          cnt = s.run_cnt + 6'h01;
        end
        // [RULE4] [RULE5] consecutive periods met
        // [RULE11] [RULE12] [RULE13] mode sets need
        if (dir != AZD_RUN_NONE && cnt >= azd_need(dir == AZD_RUN_DOWN, s.cfg[CFG_ALGO_BIT], s.ddelay)) begin
          next_s.target = link.zone;
          next_s.armed = 1'b1;
          next_s.armed_up = (dir == AZD_RUN_UP);
          next_s.run = AZD_RUN_NONE;
          next_s.run_cnt = 6'h00;
        end else begin
          next_s.run = dir;
          next_s.run_cnt = cnt;
        end
      end
    end
    // [RULE10] brightness from zone target
    next_s.bright = (s.target > 3'h4) ? s.tgt4 : tgt_all[8 * s.target +: 8];
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= CONFIG_RESET;
      s.ddelay <= DOWN_DELAY_RESET;
      s.bnd_hi <= BOUND_HIGH_RESET;
      s.bnd_lo <= BOUND_LOW_RESET;
      s.tgt_lo <= TARGET_LOW_RESET;
      s.tgt4 <= TARGET_FOUR_RESET;
    end else begin
      s <= next_s;
    end
  end
  // ****************
  // sub blocks and outputs
  // ****************
  assign link.clear = start;
  assign link.sample_tick = s.tick;
  assign link.sample_data = sample_data;
  assign link.period_end = s.per_end;
  assign link.bnd_hi = s.bnd_hi;
  assign link.bnd_lo = s.bnd_lo;
  azd_averager u_avg (.sys_clk(sys_clk), .rst(rst), .lk(link));
  azd_zone_map u_zone (.sys_clk(sys_clk), .rst(rst), .lk(link));
  assign hreadyout = (s.bus != AZD_BUS_WAIT);
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign sample_strobe = s.tick;
  assign conv_enable = en;
  assign brightness = s.bright;
  assign target_zone = s.target;
  assign irq_out = 1'b0;
  // [RULE14] open drain pulls low
  assign irq_oe_n = !(s.flag && en);
  // ****************
  // checks
  // ****************
  property p_start;
    @(posedge sys_clk) disable iff (rst)
    start |=> (s.target == 3'h0 && s.prev_zone == 3'h0 && s.fast_left == FAST_PERIODS);
  endproperty
  a_start: assert property (p_start) else $error("start state wrong"); // [RULE2]
  property p_fast_len;
    @(posedge sys_clk) disable iff (rst)
    (en && !start && s.fast_left != 2'h0 && s.per_cnt == FAST_CYC - 1) |=> s.per_end;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast period length wrong"); // [RULE3]
  property p_up;
    @(posedge sys_clk) disable iff (rst)
    (link.zone_valid && !start && s.fast_zv == 2'h0 && !s.armed && s.run == AZD_RUN_UP && s.run_cnt == 6'h02
      && !dn) |=> (s.armed && s.target == $past(link.zone));
  endproperty
  a_up: assert property (p_up) else $error("upward move missed"); // [RULE4]
  property p_down;
    @(posedge sys_clk) disable iff (rst)
    (link.zone_valid && !start && s.fast_zv == 2'h0 && !s.armed && s.run == AZD_RUN_DOWN && !up
      && s.run_cnt == azd_need(1'b1, s.cfg[CFG_ALGO_BIT], s.ddelay) - 6'h01) |=> (s.target == $past(link.zone));
  endproperty
  a_down: assert property (p_down) else $error("downward move missed"); // [RULE5]
  property p_down_wait;
    @(posedge sys_clk) disable iff (rst)
    (link.zone_valid && !start && s.fast_zv == 2'h0 && !s.armed && s.run == AZD_RUN_DOWN && !up
      && s.run_cnt + 6'h01 < azd_need(1'b1, s.cfg[CFG_ALGO_BIT], s.ddelay)) |=> $stable(s.target);
  endproperty
  a_down_wait: assert property (p_down_wait) else $error("decrease before delay"); // [RULE13]
  property p_same_dir;
    @(posedge sys_clk) disable iff (rst)
    (link.zone_valid && !start && s.fast_zv == 2'h0 && s.armed && s.armed_up && up)
      |=> (s.target == $past(link.zone) && s.armed);
  endproperty
  a_same_dir: assert property (p_same_dir) else $error("same direction not immediate"); // [RULE6]
  property p_disarm;
    @(posedge sys_clk) disable iff (rst)
    (link.zone_valid && !start && s.fast_zv == 2'h0 && s.armed && !up && !dn)
      |=> (!s.armed && s.run == AZD_RUN_NONE && $stable(s.target));
  endproperty
  a_disarm: assert property (p_disarm) else $error("criterion not rearmed"); // [RULE7]
  property p_boundary;
    @(posedge sys_clk) disable iff (rst)
    ($changed(s.target) && !$past(start)) |-> $past(link.zone_valid);
  endproperty
  a_boundary: assert property (p_boundary) else $error("target changed mid period"); // [RULE9]
  property p_abandon;
    @(posedge sys_clk) disable iff (rst)
    (link.zone_valid && !start && s.fast_zv == 2'h0 && !s.armed && s.run == AZD_RUN_DOWN && up)
      |=> (s.run == AZD_RUN_UP && s.run_cnt == 6'h01);
  endproperty
  a_abandon: assert property (p_abandon) else $error("pending decrease kept"); // [RULE17]
  property p_irq_set;
    @(posedge sys_clk) disable iff (rst)
    (zone_new && !start) |=> (s.flag && s.info_zone == $past(link.zone) && !irq_oe_n);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("zone interrupt missed"); // [RULE15]
  property p_irq_clear;
    @(posedge sys_clk) disable iff (rst)
    (s.bus == AZD_BUS_WAIT && !s.wr && s.addr == REG_ZONE_INFO && !zone_new) |=> (!s.flag && irq_oe_n);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("read did not clear flag"); // [RULE16]
  property p_idle;
    @(posedge sys_clk) disable iff (rst)
    !en |=> (!s.tick && !s.per_end);
  endproperty
  a_idle: assert property (p_idle) else $error("sensing while disabled"); // [RULE18]
endmodule
`default_nettype wire

// file: tb/azd_sensor_model.sv
// behavioural model of the converter feeding the decision block
`timescale 1ns/10ps
`default_nettype none
module azd_sensor_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_enable,
  input wire logic [7:0] level,
  output logic [7:0] sample_data
);
  // ****************
  // converter output
  // ****************
  // a released input shows no stale value, it toggles instead
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_data <= 8'h00;
    end else if (conv_enable) begin
      sample_data <= level;
    end else begin
      sample_data <= ~sample_data;
    end
  end
endmodule
`default_nettype wire

// file: tb/ambient_zone_decision_bench.sv
// self-checking bench of the ambient zone decision block
`timescale 1ns/10ps
`default_nettype none
module ambient_zone_decision_bench import azd_pkg::*;;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, sample_strobe, conv_enable, irq_out, irq_oe_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [7:0] sample_data, brightness, lvl;
  logic [2:0] target_zone;
  int n_fail, tests_run;
  azd_top #(.SAMPLE_CYC(4), .FAST_CYC(40), .BASE_CYC(64)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_data(sample_data), .sample_strobe(sample_strobe), .conv_enable(conv_enable),
    .brightness(brightness), .target_zone(target_zone), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  azd_sensor_model i_model (.sys_clk(sys_clk), .rst(rst), .conv_enable(conv_enable), .level(lvl),
    .sample_data(sample_data));
  // ****************
  // helpers
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (!r) begin
      @(negedge sys_clk);
      r = (hreadyout === 1'b1);
      d = hrdata;
      @(posedge sys_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(name, d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ****************
  // clock, reset, watchdog
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    cyc(5000);
    n_fail++;
    close_out();
  end
  // ****************
  // tests
  // ****************
  initial begin
    n_fail = 0;
    tests_run = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    lvl = 8'hf0;
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    wr(8'h24, 32'hffffffff);
    rd_chk("config", REG_CONFIG, 32'h0);
    rd_chk("down_delay", REG_DOWN_DELAY, 32'h0);
    rd_chk("bound_high", REG_BOUND_HIGH, BOUND_HIGH_RESET);
    rd_chk("bound_low", REG_BOUND_LOW, BOUND_LOW_RESET);
    rd_chk("target_low", REG_TARGET_LOW, TARGET_LOW_RESET);
    rd_chk("target_four", REG_TARGET_FOUR, {24'h0, TARGET_FOUR_RESET});
    rd_chk("unmapped", 8'h24, 32'h0);
    chk("conv_enable", {31'h0, conv_enable}, 32'h0);
    // sensing on, start at zone 0
    wr(REG_CONFIG, 32'h08);
    chk("conv_enable", {31'h0, conv_enable}, 32'h1);
    chk("start zone", {29'h0, target_zone}, 32'h0);
    cyc(130);
    chk("startup zone", {29'h0, target_zone}, 32'h4);
    chk("startup bright", {24'h0, brightness}, {24'h0, TARGET_FOUR_RESET});
    chk("irq low", {31'h0, irq_oe_n}, 32'h0);
    rd_chk("avg", REG_AVG_RESULT, 32'hf0);
    rd_chk("zone info", REG_ZONE_INFO, 32'h0c);
    chk("irq released", {31'h0, irq_oe_n}, 32'h1);
    rd_chk("info cleared", REG_ZONE_INFO, 32'h04);
    // direct mode, fall to zone 2
    lvl <= 8'h70;
    cyc(120);
    chk("no early fall", {29'h0, target_zone}, 32'h4);
    cyc(80);
    chk("fall zone", {29'h0, target_zone}, 32'h2);
    chk("fall bright", {24'h0, brightness}, {24'h0, TARGET_LOW_RESET[23:16]});
    cyc(64);
    // down-delay code 2 needs 8 periods
    wr(REG_CONFIG, 32'h09);
    wr(REG_DOWN_DELAY, 32'h02);
    rd_chk("down_delay", REG_DOWN_DELAY, 32'h02);
    lvl <= 8'h40;
    cyc(440);
    chk("delayed hold", {29'h0, target_zone}, 32'h2);
    cyc(90);
    chk("delayed fall", {29'h0, target_zone}, 32'h1);
    chk("delayed bright", {24'h0, brightness}, {24'h0, TARGET_LOW_RESET[15:8]});
    rd_chk("status", REG_STATUS, {16'h0, TARGET_LOW_RESET[15:8], 1'b1, 3'h1, 1'b0, 3'h1});
    lvl <= 8'h20;
    cyc(135);
    chk("decrease pending", {29'h0, target_zone}, 32'h1);
    lvl <= 8'hb0;
    cyc(150);
    chk("no early rise", {29'h0, target_zone}, 32'h1);
    cyc(50);
    chk("rise zone", {29'h0, target_zone}, 32'h3);
    chk("rise bright", {24'h0, brightness}, {24'h0, TARGET_LOW_RESET[31:24]});
    lvl <= 8'hf0;
    cyc(64);
    chk("next rise", {29'h0, target_zone}, 32'h4);
    chk("next bright", {24'h0, brightness}, {24'h0, TARGET_FOUR_RESET});
    wr(REG_CONFIG, 32'h00);
    chk("conv off", {31'h0, conv_enable}, 32'h0);
    chk("irq off", {31'h0, irq_oe_n}, 32'h1);
    cyc(2);
    chk("strobe off", {31'h0, sample_strobe}, 32'h0);
    chk("irq data", {31'h0, irq_out}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
